//--- pbc_pkg.sv
package pbc_pkg;

   // ------------------------------------------------------------
   // configuration space placement
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_OFFSET  = 8'h04;
   localparam logic [15:0] CMD_RESET   = 16'h0000;
   // bits software may change: 0,1,2,5,6,8
   localparam logic [15:0] CMD_WR_MASK = 16'h0167;

   // ------------------------------------------------------------
   // command register field positions
   // ------------------------------------------------------------
   localparam int IO_EN_BIT     = 0;
   localparam int MEM_EN_BIT    = 1;
   localparam int MASTER_EN_BIT = 2;
   localparam int SPCYC_EN_BIT  = 3;
   localparam int MWI_EN_BIT    = 4;
   localparam int VGA_SNOOP_BIT = 5;
   localparam int PERR_RESP_BIT = 6;
   localparam int WAIT_CYC_BIT  = 7;
   localparam int SERR_EN_BIT   = 8;
   localparam int FB2B_EN_BIT   = 9;

   // ------------------------------------------------------------
   // bus commands and palette addresses
   // ------------------------------------------------------------
   localparam logic [3:0] BC_SPECIAL = 4'h1;
   localparam logic [3:0] BC_IO_RD   = 4'h2;
   localparam logic [3:0] BC_IO_WR   = 4'h3;
   localparam logic [3:0] BC_MEM_RD  = 4'h6;
   localparam logic [3:0] BC_MEM_WR  = 4'h7;
   localparam logic [3:0] BC_CFG_RD  = 4'ha;
   localparam logic [3:0] BC_CFG_WR  = 4'hb;
   localparam logic [3:0] BC_MEM_RDM = 4'hc;
   localparam logic [3:0] BC_MEM_RDL = 4'he;
   localparam logic [3:0] BC_MWI     = 4'hf;

   localparam logic [9:0] VGA_PAL_A  = 10'h3c6;
   localparam logic [9:0] VGA_PAL_B  = 10'h3c8;
   localparam logic [9:0] VGA_PAL_C  = 10'h3c9;

   function automatic logic is_io(input logic [3:0] c);
      return (c == BC_IO_RD) || (c == BC_IO_WR);
   endfunction

   function automatic logic is_mem(input logic [3:0] c);
      return (c == BC_MEM_RD) || (c == BC_MEM_WR) ||
             (c == BC_MEM_RDM) || (c == BC_MEM_RDL) ||
             (c == BC_MWI);
   endfunction

   function automatic logic is_cfg(input logic [3:0] c);
      return (c == BC_CFG_RD) || (c == BC_CFG_WR);
   endfunction

endpackage

//--- pbc_ctl_if.sv
// enables handed from the command register to the decoders
interface pbc_ctl_if;
   logic io_en;
   logic mem_en;
   logic master_en;
   logic vga_snoop;
   logic perr_resp;
   logic serr_en;

   modport regs (output io_en, mem_en, master_en,
                 vga_snoop, perr_resp, serr_en);
   modport user (input io_en, mem_en, master_en,
                 vga_snoop, perr_resp, serr_en);
endinterface

//--- pbc_decode.sv
// claim decision for primary and secondary address phases
module pbc_decode (
   input  wire logic        clk,
   input  wire logic        rst_n,
   pbc_ctl_if.user          ctl,
   input  wire logic        pri_valid,
   input  wire logic [3:0]  pri_cmd,
   input  wire logic [31:0] pri_addr,
   input  wire logic        pri_io_win,
   input  wire logic        pri_mem_win,
   input  wire logic        sec_valid,
   input  wire logic [3:0]  sec_cmd,
   input  wire logic        sec_win,
   output logic             pri_claim,
   output logic             vga_hit,
   output logic             sec_claim
);

   logic pal_lo;
   logic next_pri;
   logic next_sec;

   // ------------------------------------------------------------
   // palette write match: bits 15:10 are don't-care
   // ------------------------------------------------------------
   assign pal_lo  = (pri_addr[9:0] == pbc_pkg::VGA_PAL_A) ||
                    (pri_addr[9:0] == pbc_pkg::VGA_PAL_B) ||
                    (pri_addr[9:0] == pbc_pkg::VGA_PAL_C);
   assign vga_hit = (pri_cmd == pbc_pkg::BC_IO_WR) && pal_lo &&
                    (pri_addr[31:16] == 16'h0000);

   // special cycles fall through every term and are never claimed
   always_comb begin
      next_pri = 1'b0;
      if (pri_valid) begin
         if (pbc_pkg::is_io(pri_cmd) && pri_io_win)
            next_pri = ctl.io_en;
         if (pbc_pkg::is_mem(pri_cmd) && pri_mem_win)
            next_pri = ctl.mem_en;
         if (vga_hit && ctl.vga_snoop)
            next_pri = 1'b1;
      end
   end

   // config forwarding ignores the master enable
   always_comb begin
      next_sec = 1'b0;
      if (sec_valid && sec_win) begin
         if (pbc_pkg::is_cfg(sec_cmd))
            next_sec = 1'b1;
         else if (pbc_pkg::is_io(sec_cmd) || pbc_pkg::is_mem(sec_cmd))
            next_sec = ctl.master_en;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pri_claim <= 1'b0;
         sec_claim <= 1'b0;
      end else begin
         pri_claim <= next_pri;
         sec_claim <= next_sec;
      end
   end

endmodule

//--- pbc_err.sv
// parity and system error pin enables, registered one cycle
module pbc_err (
   input  wire logic clk,
   input  wire logic rst_n,
   pbc_ctl_if.user   ctl,
   input  wire logic data_perr,
   input  wire logic addr_perr,
   input  wire logic sys_err_evt,
   input  wire logic dpr_cond,
   output logic      perr_oe,
   output logic      serr_oe,
   output logic      dpr_set
);

   logic serr_cause;

   // address parity may only raise the system error with response on
   assign serr_cause = (addr_perr && ctl.perr_resp) ||
                       sys_err_evt;

   // ------------------------------------------------------------
   // pin drive and status-set pulse
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         perr_oe <= 1'b0;
         serr_oe <= 1'b0;
         dpr_set <= 1'b0;
      end else begin
         perr_oe <= data_perr && ctl.perr_resp;
         dpr_set <= data_perr && dpr_cond && ctl.perr_resp;
         serr_oe <= serr_cause && ctl.serr_en;
      end
   end

endmodule

//--- pbc_cmd_reg.sv
// Notes on behaviour
// - io enable low: primary io not claimed, except palette writes with snoop enable set
// - memory enable low: primary memory ignored
// - master enable gates secondary claim, primary initiation
// - configuration forwarding ignores master enable
// - special cycle bit reads zero; cycles ignored
// - mwi bit zero; mwi only when forwarded
// - palette write: io write, 3c6/3c8/3c9, high zero
// - snoop enable claims palette writes for forwarding
// - parity response off: no perr, status, or address-parity serr
// - parity response on: perr, status, serr allowed
// - wait cycle bit zero; no stepping
// - serr enable low: serr pin never driven
// - fast back-to-back bit zero; never generated
// - bits 15:10 reserved, read zero
module pbc_cmd_reg (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  primary_cmd_byte_enable_lines,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_rvalid,
   input  wire logic        pri_valid,
   input  wire logic [3:0]  pri_cmd,
   input  wire logic [31:0] pri_addr,
   input  wire logic        pri_io_win,
   input  wire logic        pri_mem_win,
   output logic             pri_claim,
   input  wire logic        sec_valid,
   input  wire logic [3:0]  sec_cmd,
   input  wire logic        sec_win,
   output logic             sec_claim,
   input  wire logic        init_req,
   input  wire logic [3:0]  init_cmd,
   input  wire logic        init_src_mwi,
   output logic             init_go,
   output logic [3:0]       init_cmd_out,
   output logic             fast_b2b_allow,
   output logic             stepping_allow,
   input  wire logic        data_perr,
   input  wire logic        addr_perr,
   input  wire logic        sys_err_evt,
   input  wire logic        dpr_cond,
   output logic             primary_parity_error_pin_o,
   output logic             primary_parity_error_pin_oe,
   output logic             primary_system_error_pin_o,
   output logic             primary_system_error_pin_oe,
   output logic             dpr_set
);

   logic [15:0] primary_command;
   logic        hit;
   logic        vga_hit;
   logic        init_ok;
   pbc_ctl_if   ctl ();

   // ------------------------------------------------------------
   // configuration access decode
   // ------------------------------------------------------------
   // only the dword address matters; the low two bits are type bits
   assign hit = (cfg_addr[7:2] == pbc_pkg::CMD_OFFSET[7:2]);

   // ------------------------------------------------------------
   // command register
   // ------------------------------------------------------------
   // each byte lane lands only where its enable is low, and the
   // mask keeps read-only and reserved bits at zero for good
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         primary_command <= pbc_pkg::CMD_RESET;
      end else if (cfg_wr && hit) begin
         if (!primary_cmd_byte_enable_lines[0])
            primary_command[7:0] <= cfg_wdata[7:0] &
               pbc_pkg::CMD_WR_MASK[7:0];
         if (!primary_cmd_byte_enable_lines[1])
            primary_command[15:8] <= cfg_wdata[15:8] &
               pbc_pkg::CMD_WR_MASK[15:8];
      end
   end

   // read data: the status half lives in another block, reads zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_rdata  <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd && hit)
            cfg_rdata <= {16'h0000, primary_command};
         else
            cfg_rdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // enables to the decoders
   // ------------------------------------------------------------
   assign ctl.io_en     = primary_command[pbc_pkg::IO_EN_BIT];
   assign ctl.mem_en    = primary_command[pbc_pkg::MEM_EN_BIT];
   assign ctl.master_en = primary_command[pbc_pkg::MASTER_EN_BIT];
   assign ctl.vga_snoop = primary_command[pbc_pkg::VGA_SNOOP_BIT];
   assign ctl.perr_resp = primary_command[pbc_pkg::PERR_RESP_BIT];
   assign ctl.serr_en   = primary_command[pbc_pkg::SERR_EN_BIT];

   // read-only bits tie these off, so neither feature ever runs
   assign fast_b2b_allow = primary_command[pbc_pkg::FB2B_EN_BIT];
   assign stepping_allow = primary_command[pbc_pkg::WAIT_CYC_BIT];

   pbc_decode u_decode (
      .clk         (clk),
      .rst_n       (rst_n),
      .ctl         (ctl.user),
      .pri_valid   (pri_valid),
      .pri_cmd     (pri_cmd),
      .pri_addr    (pri_addr),
      .pri_io_win  (pri_io_win),
      .pri_mem_win (pri_mem_win),
      .sec_valid   (sec_valid),
      .sec_cmd     (sec_cmd),
      .sec_win     (sec_win),
      .pri_claim   (pri_claim),
      .vga_hit     (vga_hit),
      .sec_claim   (sec_claim)
   );

   pbc_err u_err (
      .clk         (clk),
      .rst_n       (rst_n),
      .ctl         (ctl.user),
      .data_perr   (data_perr),
      .addr_perr   (addr_perr),
      .sys_err_evt (sys_err_evt),
      .dpr_cond    (dpr_cond),
      .perr_oe     (primary_parity_error_pin_oe),
      .serr_oe     (primary_system_error_pin_oe),
      .dpr_set     (dpr_set)
   );

   // open-drain pins only ever pull low
   assign primary_parity_error_pin_o = 1'b0;
   assign primary_system_error_pin_o = 1'b0;

   // ------------------------------------------------------------
   // primary initiator gate
   // ------------------------------------------------------------
   // configuration passes regardless; special cycles never start
   always_comb begin
      init_ok = 1'b0;
      if (pbc_pkg::is_cfg(init_cmd))
         init_ok = 1'b1;
      else if (pbc_pkg::is_io(init_cmd) || pbc_pkg::is_mem(init_cmd))
         init_ok = ctl.master_en;
   end

   // an mwi not carried over from another master degrades to a
   // plain write, since this bridge owns no cache line policy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         init_go      <= 1'b0;
         init_cmd_out <= 4'h0;
      end else begin
         init_go <= init_req && init_ok;
         if (init_cmd == pbc_pkg::BC_MWI && !init_src_mwi)
            init_cmd_out <= pbc_pkg::BC_MEM_WR;
         else
            init_cmd_out <= init_cmd;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wr_low;
      cfg_wr && hit && !primary_cmd_byte_enable_lines[0];
   endsequence

   sequence s_wr_high;
      cfg_wr && hit && !primary_cmd_byte_enable_lines[1];
   endsequence

   sequence s_io_phase;
      pri_valid && pbc_pkg::is_io(pri_cmd) && pri_io_win && !vga_hit;
   endsequence

   sequence s_mem_phase;
      pri_valid && pbc_pkg::is_mem(pri_cmd) && pri_mem_win;
   endsequence

   property p_wr_lane;
      s_wr_low |=> primary_command[7:0] ==
         ($past(cfg_wdata[7:0]) & pbc_pkg::CMD_WR_MASK[7:0]);
   endproperty
   a_wr_lane: assert property (p_wr_lane)
      else $error("command low byte not written as masked");

   property p_wr_high;
      s_wr_high |=> primary_command[15:8] ==
         ($past(cfg_wdata[15:8]) & pbc_pkg::CMD_WR_MASK[15:8]);
   endproperty
   a_wr_high: assert property (p_wr_high)
      else $error("command high byte not written as masked");

   property p_ro_zero;
      (primary_command & ~pbc_pkg::CMD_WR_MASK) == 16'h0000;
   endproperty
   a_ro_zero: assert property (p_ro_zero)
      else $error("read-only command bit became set");

   property p_rd_data;
      cfg_rd && hit |=> cfg_rvalid &&
         cfg_rdata == {16'h0000, $past(primary_command)};
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("command read returned wrong value");

   property p_io;
      s_io_phase |=> pri_claim == $past(ctl.io_en);
   endproperty
   a_io: assert property (p_io)
      else $error("io claim disagrees with io enable");

   property p_mem;
      s_mem_phase |=> pri_claim == $past(ctl.mem_en);
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory claim disagrees with memory enable");

   property p_vga;
      pri_valid && vga_hit && ctl.vga_snoop |=> pri_claim;
   endproperty
   a_vga: assert property (p_vga)
      else $error("palette write not claimed with snoop on");

   property p_special;
      pri_valid && pri_cmd == pbc_pkg::BC_SPECIAL |=> !pri_claim;
   endproperty
   a_special: assert property (p_special)
      else $error("special cycle was claimed");

   property p_master;
      init_req && !ctl.master_en && !pbc_pkg::is_cfg(init_cmd)
         |=> !init_go;
   endproperty
   a_master: assert property (p_master)
      else $error("initiation with master enable clear");

   property p_cfg_fwd;
      sec_valid && sec_win && pbc_pkg::is_cfg(sec_cmd) |=> sec_claim;
   endproperty
   a_cfg_fwd: assert property (p_cfg_fwd)
      else $error("configuration forward blocked");

   property p_perr;
      !ctl.perr_resp ##1 !$past(ctl.perr_resp) |->
         !primary_parity_error_pin_oe && !dpr_set;
   endproperty
   a_perr: assert property (p_perr)
      else $error("parity reported with response off");

   property p_perr_on;
      data_perr && ctl.perr_resp |=> primary_parity_error_pin_oe;
   endproperty
   a_perr_on: assert property (p_perr_on)
      else $error("data parity error not driven");

   property p_serr;
      primary_system_error_pin_oe |-> $past(ctl.serr_en);
   endproperty
   a_serr: assert property (p_serr)
      else $error("system error driven while disabled");

   property p_fb2b;
      !fast_b2b_allow && !stepping_allow;
   endproperty
   a_fb2b: assert property (p_fb2b)
      else $error("fast back-to-back or stepping enabled");

   property p_mwi;
      init_cmd == pbc_pkg::BC_MWI && !init_src_mwi
         |=> init_cmd_out == pbc_pkg::BC_MEM_WR;
   endproperty
   a_mwi: assert property (p_mwi)
      else $error("own mwi issued");

   property p_addr_perr_off;
      addr_perr && !ctl.perr_resp && !sys_err_evt
         |=> !primary_system_error_pin_oe;
   endproperty
   a_addr_perr_off: assert property (p_addr_perr_off)
      else $error("address parity reported with response off");

   property p_sec_master;
      sec_valid && sec_win && !ctl.master_en && !pbc_pkg::is_cfg(sec_cmd)
         |=> !sec_claim;
   endproperty
   a_sec_master: assert property (p_sec_master)
      else $error("secondary claim with master enable clear");

   property p_dpr_on;
      data_perr && dpr_cond && ctl.perr_resp |=> dpr_set;
   endproperty
   a_dpr_on: assert property (p_dpr_on)
      else $error("data parity reported bit not set");

endmodule

//--- pbc_cfg_master.sv
// configuration master standing on the primary bus
module pbc_cfg_master (
   input  wire logic        clk,
   output logic             cfg_wr,
   output logic             cfg_rd,
   output logic [7:0]       cfg_addr,
   output logic [3:0]       be_n,
   output logic [31:0]      cfg_wdata,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // idle bus at time zero
   // ----------------------------------------
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      be_n = 4'hf;
      cfg_wdata = 32'h0;
   end

   // one data phase, held until the edge that takes it
   task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                            input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      be_n <= be;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      be_n <= 4'hf;
      cfg_wdata <= ~d; // released data must not look still valid
   endtask

   // read answer is registered, so it is picked up after the taking edge
   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
                           output logic ok);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      be_n <= 4'h0;
      @(posedge clk);
      cfg_rd <= 1'b0;
      be_n <= 4'hf;
      #1;
      ok = cfg_rvalid;
      d = cfg_rdata;
   endtask
endmodule

//--- bridge_primary_command_reg_bench.sv
module bridge_primary_command_reg_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk, rst_n, cfg_wr, cfg_rd, cfg_rvalid;
   logic [7:0]  cfg_addr;
   logic [3:0]  be_n, pri_cmd, sec_cmd, init_cmd, init_cmd_out;
   logic [31:0] cfg_wdata, cfg_rdata, pri_addr;
   logic        pri_valid, pri_io_win, pri_mem_win, pri_claim;
   logic        sec_valid, sec_win, sec_claim, init_req, init_src_mwi;
   logic        init_go, fast_b2b_allow, stepping_allow, dpr_set;
   logic        data_perr, addr_perr, sys_err_evt, dpr_cond;
   logic        perr_o, perr_oe, serr_o, serr_oe;
   int          miscompares, checks_done;

   pbc_cmd_reg uut (
      .clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr,
      .primary_cmd_byte_enable_lines(be_n), .cfg_wdata, .cfg_rdata,
      .cfg_rvalid, .pri_valid, .pri_cmd, .pri_addr, .pri_io_win,
      .pri_mem_win, .pri_claim, .sec_valid, .sec_cmd, .sec_win,
      .sec_claim, .init_req, .init_cmd, .init_src_mwi, .init_go,
      .init_cmd_out, .fast_b2b_allow, .stepping_allow, .data_perr,
      .addr_perr, .sys_err_evt, .dpr_cond,
      .primary_parity_error_pin_o(perr_o),
      .primary_parity_error_pin_oe(perr_oe),
      .primary_system_error_pin_o(serr_o),
      .primary_system_error_pin_oe(serr_oe), .dpr_set);

   pbc_cfg_master mst (
      .clk, .cfg_wr, .cfg_rd, .cfg_addr, .be_n, .cfg_wdata,
      .cfg_rdata, .cfg_rvalid);

   always #12.5 clk = ~clk;

   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] v, input logic [3:0] be);
      mst.cfg_write(pbc_pkg::CMD_OFFSET, be, {16'h0, v});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        ok;
      mst.cfg_read(a, d, ok);
      chk("cfg_rvalid", {31'h0, ok}, 32'h1);
      chk("cfg_rdata", d, exp);
   endtask

   // one primary address phase; claim shows one cycle later
   task automatic pri(input logic [3:0] c, input logic [31:0] a,
                      input logic iw, input logic mw, input logic e);
      @(posedge clk);
      pri_valid <= 1'b1;
      pri_cmd <= c;
      pri_addr <= a;
      pri_io_win <= iw;
      pri_mem_win <= mw;
      @(posedge clk);
      pri_valid <= 1'b0;
      pri_addr <= ~a;
      #1 chk("pri_claim", {31'h0, pri_claim}, {31'h0, e});
   endtask

   // secondary phase and primary initiation request side by side
   task automatic fwd(input logic [3:0] c, input logic src, input logic e,
                      input logic [3:0] ec);
      @(posedge clk);
      sec_valid <= 1'b1;
      sec_cmd <= c;
      sec_win <= 1'b1;
      init_req <= 1'b1;
      init_cmd <= c;
      init_src_mwi <= src;
      @(posedge clk);
      sec_valid <= 1'b0;
      init_req <= 1'b0;
      #1 chk("sec_claim", {31'h0, sec_claim}, {31'h0, e});
      chk("init_go", {31'h0, init_go}, {31'h0, e});
      if (e) chk("init_cmd_out", {28'h0, init_cmd_out}, {28'h0, ec});
   endtask

   task automatic err(input logic dp, input logic ap, input logic se,
                      input logic c, input logic ep, input logic es,
                      input logic ed);
      @(posedge clk);
      data_perr <= dp;
      addr_perr <= ap;
      sys_err_evt <= se;
      dpr_cond <= c;
      @(posedge clk);
      {data_perr, addr_perr, sys_err_evt, dpr_cond} <= 4'h0;
      #1 chk("perr_oe", {31'h0, perr_oe}, {31'h0, ep});
      chk("serr_oe", {31'h0, serr_oe}, {31'h0, es});
      chk("dpr_set", {31'h0, dpr_set}, {31'h0, ed});
      chk("pins_o", {30'h0, perr_o, serr_o}, 32'h0);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_fields();
      rd(8'h04, 32'h0);
      chk("ro_outs", {30'h0, fast_b2b_allow, stepping_allow},
          32'h0);
      wr(16'hffff, 4'h0);
      rd(8'h04, 32'h0167);
      chk("ro_outs", {30'h0, fast_b2b_allow, stepping_allow},
          32'h0);
      wr(16'h0000, 4'he);
      rd(8'h04, 32'h0100);
      wr(16'h0000, 4'hd);
      rd(8'h04, 32'h0000);
      mst.cfg_write(8'h08, 4'h0, 32'hffff_ffff);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
   endtask

   task automatic t_pri();
      wr(16'h0000, 4'h0);
      pri(pbc_pkg::BC_IO_WR, 32'h100, 1'b1, 1'b1, 1'b0);
      pri(pbc_pkg::BC_MEM_WR, 32'h1000, 1'b1, 1'b1, 1'b0);
      wr(16'h0001, 4'h0);
      pri(pbc_pkg::BC_IO_RD, 32'h100, 1'b1, 1'b0, 1'b1);
      pri(pbc_pkg::BC_IO_RD, 32'h100, 1'b0, 1'b0, 1'b0);
      pri(pbc_pkg::BC_MEM_RD, 32'h1000, 1'b0, 1'b1, 1'b0);
      pri(pbc_pkg::BC_IO_WR, 32'h3c8, 1'b1, 1'b0, 1'b1);
      wr(16'h0027, 4'h0);
      pri(pbc_pkg::BC_MEM_RD, 32'h1000, 1'b0, 1'b1, 1'b1);
      pri(pbc_pkg::BC_MWI, 32'h1000, 1'b0, 1'b1, 1'b1);
      pri(pbc_pkg::BC_MEM_RDM, 32'h1000, 1'b0, 1'b1, 1'b1);
      pri(pbc_pkg::BC_MEM_RDL, 32'h1000, 1'b0, 1'b1, 1'b1);
      pri(pbc_pkg::BC_SPECIAL, 32'h0, 1'b1, 1'b1, 1'b0);
      wr(16'h0020, 4'h0);
      pri(pbc_pkg::BC_IO_WR, 32'h0000_fbc6, 1'b0, 1'b0, 1'b1);
      pri(pbc_pkg::BC_IO_WR, 32'h0000_03c8, 1'b0, 1'b0, 1'b1);
      pri(pbc_pkg::BC_IO_WR, 32'h0000_7fc9, 1'b0, 1'b0, 1'b1);
      pri(pbc_pkg::BC_IO_WR, 32'h0001_03c6, 1'b0, 1'b0, 1'b0);
      pri(pbc_pkg::BC_IO_WR, 32'h0000_03c7, 1'b0, 1'b0, 1'b0);
      pri(pbc_pkg::BC_IO_RD, 32'h0000_03c6, 1'b0, 1'b0, 1'b0);
      wr(16'h0000, 4'h0);
      pri(pbc_pkg::BC_IO_WR, 32'h0000_03c6, 1'b0, 1'b0, 1'b0);
   endtask

   task automatic t_fwd();
      fwd(pbc_pkg::BC_CFG_WR, 1'b0, 1'b1, pbc_pkg::BC_CFG_WR);
      fwd(pbc_pkg::BC_IO_RD, 1'b0, 1'b0, 4'h0);
      fwd(pbc_pkg::BC_MEM_WR, 1'b0, 1'b0, 4'h0);
      wr(16'h0004, 4'h0);
      fwd(pbc_pkg::BC_IO_WR, 1'b0, 1'b1, pbc_pkg::BC_IO_WR);
      fwd(pbc_pkg::BC_MEM_RD, 1'b0, 1'b1, pbc_pkg::BC_MEM_RD);
      fwd(pbc_pkg::BC_CFG_RD, 1'b0, 1'b1, pbc_pkg::BC_CFG_RD);
      fwd(pbc_pkg::BC_MWI, 1'b0, 1'b1, pbc_pkg::BC_MEM_WR);
      fwd(pbc_pkg::BC_MWI, 1'b1, 1'b1, pbc_pkg::BC_MWI);
   endtask

   // all four settings of parity response and system error enable
   task automatic t_err();
      logic [15:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 16'h0;
         v[6] = i[0];
         v[8] = i[1];
         wr(v, 4'h0);
         err(1'b1, 1'b0, 1'b0, 1'b1, i[0], 1'b0, i[0]);
         err(1'b1, 1'b0, 1'b0, 1'b0, i[0], 1'b0, 1'b0);
         err(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, i[0] & i[1], 1'b0);
         err(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, i[1], 1'b0);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {pri_valid, pri_io_win, pri_mem_win, sec_valid, sec_win} = 5'h0;
      {init_req, init_src_mwi, data_perr, addr_perr} = 4'h0;
      {sys_err_evt, dpr_cond} = 2'h0;
      {pri_cmd, sec_cmd, init_cmd} = 12'h0;
      pri_addr = 32'h0;
      miscompares = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_fields();
      t_pri();
      t_fwd();
      t_err();
      // reset again in mid-run with everything enabled
      wr(16'h0167, 4'h0);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h04, 32'h0);
      pri(pbc_pkg::BC_IO_RD, 32'h100, 1'b1, 1'b1, 1'b0);
      err(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      end_sim();
   end
endmodule
